// ---- design/rxe_mem.sv ----
module rxe_mem (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [rxe_pkg::MEM_AW-1:0] waddr_in,
  input wire logic [rxe_pkg::MEM_DW-1:0] wdata_in,
  input wire logic [rxe_pkg::MEM_AW-1:0] raddr_in,
  output logic [rxe_pkg::MEM_DW-1:0] rdata_out
);
  logic [rxe_pkg::MEM_DW-1:0] mem [rxe_pkg::MEM_DEPTH];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule

// ---- design/rxe_top.sv ----
module rxe_top (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [15:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [15:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [3:0] mac_valid_in,
  input wire logic [31:0] mac_data_in,
  input wire logic [3:0] mac_sop_in,
  input wire logic [3:0] mac_eop_in,
  output logic [3:0] mac_ready_out,
  input wire logic lbk_valid_in,
  input wire logic [1:0] lbk_port_in,
  input wire logic [7:0] lbk_data_in,
  input wire logic lbk_sop_in,
  input wire logic lbk_eop_in,
  output logic lbk_ready_out,
  output logic sys_valid_out,
  output logic [7:0] sys_data_out,
  output logic sys_sop_out,
  output logic sys_eop_out,
  output logic [1:0] sys_port_out,
  input wire logic sys_ready_in
);
  logic [7:0] ctrl, next_ctrl;
  logic [3:0] loop_en, next_loop_en;
  logic [11:0] thr [4];
  logic [11:0] next_thr [4];
  logic wr_take, next_wr_take, rd_take, next_rd_take;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata, wmask;
  logic [13:0] widx, ridx;
  logic lbk_ready, next_lbk_ready;
  logic [11:0] wr_ptr [4];
  logic [11:0] rd_ptr [4];
  logic [11:0] next_rd_ptr [4];
  logic [11:0] occ [4];
  logic [7:0] pkt_cnt [4];
  logic [8:0] mem_wd [4];
  logic [8:0] mem_rd [4];
  logic [3:0] mem_we, eg_done, elig;
  rxe_pkg::rxe_eg_state_t state, next_state;
  logic [1:0] cur, next_cur, rr, next_rr, pick;
  logic sop_pend, next_sop_pend, found, out_free;
  logic ov, next_ov, osop, next_osop, oeop, next_oeop;
  logic [7:0] odata, next_odata;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  assign s_axi_awready_out = wr_take;
  assign s_axi_wready_out = wr_take;
  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = bresp;
  assign s_axi_arready_out = rd_take;
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rresp_out = rresp;
  assign s_axi_rdata_out = rdata;
  assign lbk_ready_out = lbk_ready;
  assign sys_valid_out = ov;
  assign sys_data_out = odata;
  assign sys_sop_out = osop;
  assign sys_eop_out = oeop;
  assign sys_port_out = cur;
  assign widx = s_axi_awaddr_in[15:2];
  assign ridx = s_axi_araddr_in[15:2];

  // register slave: address and data are taken together, one pulse of ready
  always_comb begin
    next_ctrl = ctrl;
    next_loop_en = loop_en;
    next_thr = thr;
    next_bvalid = bvalid && !s_axi_bready_in;
    next_bresp = bresp;
    next_rvalid = rvalid && !s_axi_rready_in;
    next_rresp = rresp;
    next_rdata = rdata;
    next_wr_take = s_axi_awvalid_in && s_axi_wvalid_in && !wr_take && !bvalid;
    next_rd_take = s_axi_arvalid_in && !rd_take && !rvalid;
    wmask = {{8{s_axi_wstrb_in[3]}}, {8{s_axi_wstrb_in[2]}},
             {8{s_axi_wstrb_in[1]}}, {8{s_axi_wstrb_in[0]}}};
    if (wr_take) begin
      next_bvalid = 1'b1;
      next_bresp = rxe_pkg::RESP_OKAY;
      unique case (widx)
        rxe_pkg::IDX_PAD_CRC: next_ctrl = (ctrl & ~wmask[7:0]) | (s_axi_wdata_in[7:0] & wmask[7:0]);
        rxe_pkg::IDX_LOOPBACK: next_loop_en = (loop_en & ~wmask[11:8])
                                              | (s_axi_wdata_in[11:8] & wmask[11:8]);
        rxe_pkg::IDX_THR0, rxe_pkg::IDX_THR1, rxe_pkg::IDX_THR2, rxe_pkg::IDX_THR3:
          next_thr[widx[1:0]] = (thr[widx[1:0]] & ~wmask[11:0])
                                | (s_axi_wdata_in[11:0] & wmask[11:0]);
        rxe_pkg::IDX_STATUS: next_bresp = rxe_pkg::RESP_OKAY;
        default: next_bresp = rxe_pkg::RESP_SLVERR;
      endcase
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rresp = rxe_pkg::RESP_OKAY;
      unique case (ridx)
        rxe_pkg::IDX_PAD_CRC: next_rdata = {24'h000000, ctrl};
        rxe_pkg::IDX_LOOPBACK: next_rdata = {20'h00000, loop_en, 8'h00};
        rxe_pkg::IDX_THR0, rxe_pkg::IDX_THR1, rxe_pkg::IDX_THR2, rxe_pkg::IDX_THR3:
          next_rdata = {20'h00000, thr[ridx[1:0]]};
        rxe_pkg::IDX_STATUS: next_rdata = {pkt_cnt[3], pkt_cnt[2], pkt_cnt[1], pkt_cnt[0]};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = rxe_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl <= rxe_pkg::CTRL_RESET;
      loop_en <= rxe_pkg::LOOP_RESET;
      for (int i = 0; i < 4; i++) begin
        thr[i] <= rxe_pkg::THR_RESET;
      end
      wr_take <= 1'b0;
      rd_take <= 1'b0;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
      bresp <= rxe_pkg::RESP_OKAY;
      rresp <= rxe_pkg::RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      ctrl <= next_ctrl;
      loop_en <= next_loop_en;
      thr <= next_thr;
      wr_take <= next_wr_take;
      rd_take <= next_rd_take;
      bvalid <= next_bvalid;
      rvalid <= next_rvalid;
      bresp <= next_bresp;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // loopback traffic is taken only while every looped port has room
  always_comb begin
    next_lbk_ready = |loop_en;
    for (int i = 0; i < 4; i++) begin
      if (loop_en[i] && occ[i] >= rxe_pkg::RDY_LIMIT) begin
        next_lbk_ready = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lbk_ready <= 1'b0;
    end else begin
      lbk_ready <= next_lbk_ready;
    end
  end

  for (genvar p = 0; p < 4; p++) begin : g_port
    logic v, sop, eop, acc, strip, next_strip, strip_now, mrdy, next_mrdy;
    logic [7:0] d;
    logic [31:0] dly, next_dly;
    logic [2:0] dcnt, next_dcnt, cnt_eff;
    logic [11:0] next_wr_ptr;
    logic [7:0] next_pkt_cnt;

    assign occ[p] = wr_ptr[p] - rd_ptr[p];
    assign mac_ready_out[p] = mrdy;

    always_comb begin
      v = loop_en[p] ? (lbk_valid_in && lbk_port_in == 2'(p)) : mac_valid_in[p];
      d = loop_en[p] ? lbk_data_in : mac_data_in[8*p +: 8];
      sop = loop_en[p] ? lbk_sop_in : mac_sop_in[p];
      eop = loop_en[p] ? lbk_eop_in : mac_eop_in[p];
      acc = v && (loop_en[p] ? lbk_ready : mrdy);
      strip_now = (acc && sop) ? ctrl[rxe_pkg::STRIP_LSB + p] : strip;
      cnt_eff = sop ? 3'h0 : dcnt;
      next_strip = strip_now;
      next_dly = dly;
      next_dcnt = dcnt;
      mem_we[p] = 1'b0;
      mem_wd[p] = {eop, d};
      if (acc) begin
        next_dly = {dly[23:0], d};
        next_dcnt = eop ? 3'h0 : ((cnt_eff == rxe_pkg::CRC_BYTES) ? cnt_eff : cnt_eff + 3'h1);
        // four bytes lag behind; at the end they are the CRC and are dropped
        if (strip_now) begin
          mem_we[p] = (cnt_eff == rxe_pkg::CRC_BYTES);
          mem_wd[p] = {eop, dly[31:24]};
        end else begin
          mem_we[p] = 1'b1;
        end
      end
      next_wr_ptr = wr_ptr[p] + {11'h000, mem_we[p]};
      next_pkt_cnt = pkt_cnt[p] + {7'h00, mem_we[p] && mem_wd[p][8]} - {7'h00, eg_done[p]};
      next_mrdy = (occ[p] < rxe_pkg::RDY_LIMIT) && !loop_en[p];
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        strip <= 1'b0;
        dly <= 32'h00000000;
        dcnt <= 3'h0;
        wr_ptr[p] <= 12'h000;
        pkt_cnt[p] <= 8'h00;
        mrdy <= 1'b0;
      end else begin
        strip <= next_strip;
        dly <= next_dly;
        dcnt <= next_dcnt;
        wr_ptr[p] <= next_wr_ptr;
        pkt_cnt[p] <= next_pkt_cnt;
        mrdy <= next_mrdy;
      end
    end

    rxe_mem u_mem (
      .clk_in(clk_in),
      .we_in(mem_we[p]),
      .waddr_in(wr_ptr[p][10:0]),
      .wdata_in(mem_wd[p]),
      .raddr_in(rd_ptr[p][10:0]),
      .rdata_out(mem_rd[p])
    );

    // a complete packet, or an open one past the threshold in 8-byte locations
    assign elig[p] = (pkt_cnt[p] != 8'h00)
                     || (occ[p] != 12'h000 && {3'h0, occ[p][11:rxe_pkg::LOC_SHIFT]} >= thr[p]);
  end

  // egress toward the system side, round robin over eligible ports
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_rr = rr;
    next_sop_pend = sop_pend;
    next_rd_ptr = rd_ptr;
    next_ov = ov && !sys_ready_in;
    next_odata = odata;
    next_osop = osop;
    next_oeop = oeop;
    eg_done = 4'h0;
    found = 1'b0;
    pick = rr;
    out_free = !ov || sys_ready_in;
    for (int i = 0; i < 4; i++) begin
      if (!found && elig[rr + 2'(i)]) begin
        found = 1'b1;
        pick = rr + 2'(i);
      end
    end
    unique case (state)
      rxe_pkg::EG_IDLE: begin
        if (found) begin
          next_cur = pick;
          next_sop_pend = 1'b1;
          next_state = ctrl[rxe_pkg::PREPEND_LSB + pick] ? rxe_pkg::EG_PRE0 : rxe_pkg::EG_READ;
        end
      end
      rxe_pkg::EG_PRE0, rxe_pkg::EG_PRE1: begin
        if (out_free) begin
          next_ov = 1'b1;
          next_odata = rxe_pkg::PAD_BYTE;
          next_osop = (state == rxe_pkg::EG_PRE0);
          next_oeop = 1'b0;
          next_sop_pend = 1'b0;
          next_state = (state == rxe_pkg::EG_PRE0) ? rxe_pkg::EG_PRE1 : rxe_pkg::EG_READ;
        end
      end
      rxe_pkg::EG_READ: begin
        if (out_free && occ[cur] != 12'h000) begin
          next_rd_ptr[cur] = rd_ptr[cur] + 12'h001;
          next_state = rxe_pkg::EG_WAIT;
        end
      end
      rxe_pkg::EG_WAIT: begin
        next_ov = 1'b1;
        next_odata = mem_rd[cur][7:0];
        next_osop = sop_pend;
        next_oeop = mem_rd[cur][8];
        next_sop_pend = 1'b0;
        if (mem_rd[cur][8]) begin
          eg_done[cur] = 1'b1;
          next_rr = cur + 2'h1;
          next_state = rxe_pkg::EG_IDLE;
        end else begin
          next_state = rxe_pkg::EG_READ;
        end
      end
      default: next_state = rxe_pkg::EG_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= rxe_pkg::EG_IDLE;
      cur <= 2'h0;
      rr <= 2'h0;
      sop_pend <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        rd_ptr[i] <= 12'h000;
      end
      ov <= 1'b0;
      odata <= 8'h00;
      osop <= 1'b0;
      oeop <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      rr <= next_rr;
      sop_pend <= next_sop_pend;
      rd_ptr <= next_rd_ptr;
      ov <= next_ov;
      odata <= next_odata;
      osop <= next_osop;
      oeop <= next_oeop;
    end
  end

  sequence s_pad_start;
    state == rxe_pkg::EG_PRE0 && out_free;
  endsequence
  sequence s_pad_bytes;
    sys_valid_out && sys_sop_out && sys_data_out == rxe_pkg::PAD_BYTE;
  endsequence
  property p_pad_zero;
    s_pad_start |=> s_pad_bytes;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("prepend byte wrong");
  property p_prepend_path;
    state == rxe_pkg::EG_IDLE && found && ctrl[rxe_pkg::PREPEND_LSB + pick]
      |=> state == rxe_pkg::EG_PRE0;
  endproperty
  a_prepend_path: assert property (p_prepend_path) else $error("prepend skipped");
  property p_ctrl_reset;
    $rose(resetn_in) |-> ctrl == rxe_pkg::CTRL_RESET && thr[0] == rxe_pkg::THR_RESET;
  endproperty
  a_ctrl_reset: assert property (@(posedge clk_in) p_ctrl_reset) else $error("bad reset value");
  property p_thr_read;
    rd_take && ridx == rxe_pkg::IDX_THR0 |=> rvalid && rdata == {20'h00000, $past(thr[0])};
  endproperty
  a_thr_read: assert property (p_thr_read) else $error("threshold readback wrong");
  property p_cut_through;
    state == rxe_pkg::EG_IDLE && pkt_cnt[0] == 8'h00 && occ[0] != 12'h000
      && {3'h0, occ[0][11:3]} >= thr[0] && rr == 2'h0 |=> cur == 2'h0 && state != rxe_pkg::EG_IDLE;
  endproperty
  a_cut_through: assert property (p_cut_through) else $error("cut-through not started");
  property p_store_forward;
    state == rxe_pkg::EG_IDLE ##1 state != rxe_pkg::EG_IDLE
      |-> pkt_cnt[cur] != 8'h00 || {3'h0, occ[cur][11:3]} >= thr[cur];
  endproperty
  a_store_forward: assert property (p_store_forward) else $error("packet started early");
  property p_strip_lag;
    g_port[0].acc && g_port[0].strip_now && g_port[0].cnt_eff < rxe_pkg::CRC_BYTES
      |=> wr_ptr[0] == $past(wr_ptr[0]);
  endproperty
  a_strip_lag: assert property (p_strip_lag) else $error("crc bytes written");
  property p_loop_block;
    |loop_en |=> (mac_ready_out & $past(loop_en)) == 4'h0;
  endproperty
  a_loop_block: assert property (p_loop_block) else $error("mac accepted in loopback");
  property p_ctrl_write;
    wr_take && widx == rxe_pkg::IDX_PAD_CRC && s_axi_wstrb_in[0]
      |=> ctrl == $past(s_axi_wdata_in[7:0]) && bvalid;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
endmodule

// ---- pkg/rxe_pkg.sv ----
package rxe_pkg;
  localparam int unsigned NPORT = 4;
  localparam int unsigned MEM_AW = 11;
  localparam int unsigned MEM_DEPTH = 2048;
  localparam int unsigned MEM_DW = 9;
  localparam int unsigned PTR_W = 12;
  localparam int unsigned AXI_AW = 16;
  // register indices; byte address is index times four
  localparam logic [13:0] IDX_LOOPBACK = 14'h05B2;
  localparam logic [13:0] IDX_PAD_CRC = 14'h05B3;
  localparam logic [13:0] IDX_THR0 = 14'h05B8;
  localparam logic [13:0] IDX_THR1 = 14'h05B9;
  localparam logic [13:0] IDX_THR2 = 14'h05BA;
  localparam logic [13:0] IDX_THR3 = 14'h05BB;
  localparam logic [13:0] IDX_STATUS = 14'h05C0;
  localparam int unsigned PREPEND_LSB = 0;
  localparam int unsigned STRIP_LSB = 4;
  localparam int unsigned LOOP_LSB = 8;
  localparam int unsigned THR_W = 12;
  localparam int unsigned LOC_SHIFT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] LOOP_RESET = 4'h0;
  localparam logic [11:0] THR_RESET = 12'h0BE;
  localparam logic [2:0] CRC_BYTES = 3'h4;
  localparam logic [11:0] RDY_LIMIT = 12'h7FC;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {EG_IDLE, EG_PRE0, EG_PRE1, EG_READ, EG_WAIT} rxe_eg_state_t;
endpackage

// ---- test/rxe_sys_sink.sv ----
module rxe_sys_sink (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic slow_in,
  input wire logic sys_valid_in,
  input wire logic [7:0] sys_data_in,
  input wire logic sys_sop_in,
  input wire logic sys_eop_in,
  input wire logic [1:0] sys_port_in,
  output logic sys_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // each entry: sop, eop, port, data
  logic [11:0] got[$];
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sys_ready_out <= 1'h0;
    end else begin
      if (sys_valid_in && sys_ready_out) begin
        got.push_back({sys_sop_in, sys_eop_in, sys_port_in, sys_data_in});
      end
      // slow mode stalls the stream every other cycle
      sys_ready_out <= slow_in ? !sys_ready_out : 1'h1;
    end
  end
endmodule

// ---- test/rxe_top_tb.sv ----
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); \
  end \
end

module rxe_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, lbk_valid, lbk_sop, lbk_eop, lbk_ready;
  logic sys_valid, sys_sop, sys_eop, sys_ready, slow;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, mac_data;
  logic [1:0] bresp, rresp, lbk_port, sys_port;
  logic [3:0] mac_valid, mac_sop, mac_eop, mac_ready;
  logic [7:0] lbk_data, sys_data;
  int mismatches, n_compared, cycles, chk_lo, chk_hi;

  rxe_top DUT (
    .clk_in(clk), .resetn_in(resetn),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .mac_valid_in(mac_valid), .mac_data_in(mac_data), .mac_sop_in(mac_sop),
    .mac_eop_in(mac_eop), .mac_ready_out(mac_ready),
    .lbk_valid_in(lbk_valid), .lbk_port_in(lbk_port), .lbk_data_in(lbk_data),
    .lbk_sop_in(lbk_sop), .lbk_eop_in(lbk_eop), .lbk_ready_out(lbk_ready),
    .sys_valid_out(sys_valid), .sys_data_out(sys_data), .sys_sop_out(sys_sop),
    .sys_eop_out(sys_eop), .sys_port_out(sys_port), .sys_ready_in(sys_ready)
  );

  rxe_sys_sink sink (
    .clk_in(clk), .resetn_in(resetn), .slow_in(slow), .sys_valid_in(sys_valid),
    .sys_data_in(sys_data), .sys_sop_in(sys_sop), .sys_eop_in(sys_eop),
    .sys_port_in(sys_port), .sys_ready_out(sys_ready)
  );

  always #5 clk = ~clk;

  function automatic logic [7:0] pat(input int p, input int i);
    return 8'(i * 7 + p * 40 + 3);
  endfunction

  task automatic test_done;
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      test_done;
    end
  end

  task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 0;
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done) begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        done = 1;
        bready <= 1'h0;
        `CHK(bresp, er)
      end
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [13:0] idx, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    done = 0;
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        done = 1;
        rready <= 1'h0;
        `CHK(rdata, ed)
        `CHK(rresp, er)
      end
    end
    @(posedge clk);
  endtask

  // one packet, bytes back to back, from the mac side or the loopback side
  task automatic send(input int p, input bit lb, input int n);
    for (int i = 0; i < n; i++) begin
      if (lb) begin
        lbk_valid <= 1'h1;
        lbk_port <= 2'(p);
        lbk_data <= pat(p, i);
        lbk_sop <= (i == 0);
        lbk_eop <= (i == n - 1);
      end else begin
        mac_valid[p] <= 1'h1;
        mac_data[8*p +: 8] <= pat(p, i);
        mac_sop[p] <= (i == 0);
        mac_eop[p] <= (i == n - 1);
      end
      do @(posedge clk); while ((lb ? lbk_ready : mac_ready[p]) !== 1'h1);
      if (i == chk_lo) `CHK(sink.got.size(), 0)
      if (i == chk_hi) `CHK(sink.got.size() > 0, 1'h1)
    end
    mac_valid <= 4'h0;
    lbk_valid <= 1'h0;
    @(posedge clk);
  endtask

  task automatic expect_pkt(input int p, input int n, input bit strip, input bit pre);
    int m;
    int w;
    logic [11:0] e;
    m = n - (strip ? 4 : 0) + (pre ? 2 : 0);
    w = 0;
    while (sink.got.size() < m && w < 5000) begin
      @(posedge clk);
      w++;
    end
    repeat (8) @(posedge clk);
    `CHK(sink.got.size(), m)
    for (int k = 0; k < m && k < sink.got.size(); k++) begin
      e = {(k == 0), (k == m - 1), 2'(p), pat(p, k - (pre ? 2 : 0))};
      if (pre && k < 2) e[7:0] = rxe_pkg::PAD_BYTE;
      `CHK(sink.got[k], e)
    end
    sink.got.delete();
  endtask

  initial begin
    {clk, resetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {lbk_valid, lbk_sop, lbk_eop, lbk_port, lbk_data} = '0;
    {awaddr, araddr, wdata, mac_data, mac_valid, mac_sop, mac_eop} = '0;
    {mismatches, n_compared, cycles} = '0;
    chk_lo = -1;
    chk_hi = -1;
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    rd(rxe_pkg::IDX_PAD_CRC, 32'h0000_0000, rxe_pkg::RESP_OKAY);
    for (int p = 0; p < 4; p++) begin
      rd(rxe_pkg::IDX_THR0 + 14'(p), 32'h0000_00BE, rxe_pkg::RESP_OKAY);
    end
    wr(rxe_pkg::IDX_PAD_CRC, 32'hFFFF_FFFF, rxe_pkg::RESP_OKAY);
    rd(rxe_pkg::IDX_PAD_CRC, 32'h0000_00FF, rxe_pkg::RESP_OKAY);
    wr(rxe_pkg::IDX_THR1, 32'hFFFF_FFFF, rxe_pkg::RESP_OKAY);
    rd(rxe_pkg::IDX_THR1, 32'h0000_0FFF, rxe_pkg::RESP_OKAY);
    wr(rxe_pkg::IDX_THR1, 32'h0000_00BE, rxe_pkg::RESP_OKAY);
    wr(14'h05B4, 32'h0000_0001, rxe_pkg::RESP_SLVERR);
    rd(14'h05B4, 32'h0000_0000, rxe_pkg::RESP_SLVERR);
    wr(rxe_pkg::IDX_PAD_CRC, 32'h0000_0000, rxe_pkg::RESP_OKAY);
    send(0, 0, 8);
    expect_pkt(0, 8, 0, 0);
    // strip and prepend per port, with the system side stalling on odd ports
    for (int p = 0; p < 4; p++) begin
      slow <= p[0];
      wr(rxe_pkg::IDX_PAD_CRC, 32'(8'h11 << p), rxe_pkg::RESP_OKAY);
      send(p, 0, 9);
      expect_pkt(p, 9, 1, 1);
    end
    slow <= 1'h0;
    wr(rxe_pkg::IDX_PAD_CRC, 32'h0000_0000, rxe_pkg::RESP_OKAY);
    // threshold 0xBE locations is 1520 bytes: byte index 1519 completes it
    chk_lo = 1518;
    chk_hi = 1535;
    send(0, 0, 1600);
    expect_pkt(0, 1600, 0, 0);
    chk_lo = -1;
    chk_hi = -1;
    wr(rxe_pkg::IDX_LOOPBACK, 32'h0000_0800, rxe_pkg::RESP_OKAY);
    rd(rxe_pkg::IDX_LOOPBACK, 32'h0000_0800, rxe_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    `CHK(mac_ready[3], 1'h0)
    send(3, 1, 7);
    expect_pkt(3, 7, 0, 0);
    rd(rxe_pkg::IDX_STATUS, 32'h0000_0000, rxe_pkg::RESP_OKAY);
    wr(rxe_pkg::IDX_LOOPBACK, 32'h0000_0000, rxe_pkg::RESP_OKAY);
    test_done;
  end
endmodule
